/* bench/tb_wrs_supervisor.sv */
// Self-checking bench of the reset and watchdog supervisor
`timescale 1ns/1ps
module tb_wrs_supervisor
  import wrs_pkg::*;
;
  localparam int unsigned DLY = 20;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0, vcc_i = 1'b0, uv_i = 1'b0, dev_i = 1'b0, clr_i = 1'b0, fse_i = 1'b0;
  logic [1:0] cfg_i = 2'h0;
  logic cs_i, mwr_i, wwr_i, cwr_i, srro_i, srro_o, rst_n, wt_o, sf_o, run_o;
  logic [1:0] mode_i, thr_i, thr_o, cnt_o;
  logic [2:0] st_o, per_o;
  logic [7:0] wcr_i;
  int miscompares = 0, checked = 0, n;
  always #4 clk_i = ~clk_i;
  wrs_host_model i_wrs_host_model (.clk_i(clk_i), .cs_rise_o(cs_i), .mode_wr_o(mwr_i),
    .mode_field_o(mode_i), .wcr_wr_o(wwr_i), .wcr_data_o(wcr_i), .cfg_wr_o(cwr_i),
    .srro_o(srro_i), .thr_o(thr_i));
  wrs_supervisor #(.FILTER_CYC(4), .DELAY_CYC(DLY), .MS_CYC(10), .LONG_CYC(200))
    i_wrs_supervisor (.clk_i(clk_i), .nrst_i(nrst_i), .vcc_good_i(vcc_i), .uv_event_i(uv_i),
    .fail_safe_event_i(fse_i), .dev_mode_i(dev_i), .config_sel_i(cfg_i), .cs_rise_i(cs_i),
    .mode_wr_i(mwr_i), .mode_field_i(mode_i), .wcr_wr_i(wwr_i), .wcr_data_i(wcr_i),
    .cfg_wr_i(cwr_i), .softrst_pulses_reset_out_i(srro_i), .uv_threshold_i(thr_i),
    .wd_stop_off_i(1'b0), .spi_fail_clr_i(clr_i), .reset_out_n_o(rst_n), .state_o(st_o),
    .window_type_select_o(wt_o), .period_select_field_o(per_o),
    .trigger_failure_count_o(cnt_o), .uv_threshold_o(thr_o),
    .softrst_pulses_reset_out_o(srro_o), .spi_fail_o(sf_o), .wd_running_o(run_o));
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Counts edges until the reset output shows lvl, giving up after lim
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (rst_n !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    chk("reset_level", {7'h0, lvl}, {7'h0, rst_n});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    $display("ERROR run expected end seen hang");
    wrap_up();
  end
  initial begin
    tick(12);
    chk("dflt", {WRS_ST_INIT, 3'h1, 1'b0, 1'b1}, {st_o, per_o, wt_o, srro_o});
    chk("dflt2", 8'h0, {2'h0, thr_o, cnt_o, sf_o, rst_n});
    nrst_i = 1'b1;
    tick(30);
    chk("hold_low", 8'h0, {7'h0, rst_n});
    vcc_i = 1'b1;
    wait_rst(1'b1, 60);
    chk("rel_delay", 8'h1, {7'h0, n >= DLY && n <= DLY + 3});
    i_wrs_host_model.wd_write(3'h2, 1'b0, 1'b1);
    chk("bad_par", {4'h0, 1'b1, WRS_ST_INIT}, {4'h0, sf_o, st_o});
    clr_i = 1'b1;
    tick(1);
    clr_i = 1'b0;
    tick(1);
    chk("sf_clr", 8'h0, {7'h0, sf_o});
    for (int p = 7; p >= 1; p--) begin
      i_wrs_host_model.wd_write(3'(p), 1'b0, 1'b0);
      chk("period", {WRS_ST_NORMAL, 3'(p), 1'b1}, {st_o, per_o, run_o});
    end
    i_wrs_host_model.cfg_write(1'b1, 2'h2);
    chk("thr_set", 8'h2, {6'h0, thr_o});
    wait_rst(1'b0, 130);
    chk("tmo_time", 8'h1, {7'h0, n >= 93 && n <= 101});
    chk("tmo_fail", {WRS_ST_RESTART, 2'h1}, {st_o, cnt_o});
    wait_rst(1'b1, DLY + 10);
    chk("after_wd", {WRS_ST_NORMAL, 2'h1}, {st_o, cnt_o});
    tick(150);
    i_wrs_host_model.wd_write(3'h1, 1'b0, 1'b0);
    chk("long_win", {1'b1, 2'h0}, {rst_n, cnt_o});
    i_wrs_host_model.wd_write(3'h1, 1'b1, 1'b0);
    chk("win_set", {1'b1, 3'h1}, {wt_o, per_o});
    tick(20);
    i_wrs_host_model.wd_write(3'h1, 1'b1, 1'b0);
    wait_rst(1'b0, 6);
    chk("closed", 8'h1, {6'h0, cnt_o});
    wait_rst(1'b1, DLY + 10);
    tick(10);
    i_wrs_host_model.wd_write(3'h1, 1'b1, 1'b0);
    tick(75);
    i_wrs_host_model.wd_write(3'h1, 1'b1, 1'b0);
    chk("open_ok", 8'h4, {5'h0, rst_n, cnt_o});
    i_wrs_host_model.cfg_write(1'b0, 2'h2);
    i_wrs_host_model.mode_write(WRS_MODE_SOFTRST);
    tick(4);
    chk("soft_q", {1'b1, WRS_ST_INIT, 3'h1, 1'b0}, {rst_n, st_o, per_o, wt_o});
    chk("soft_dflt", 8'h4, {5'h0, srro_o, thr_o});
    i_wrs_host_model.mode_write(WRS_MODE_SOFTRST);
    tick(4);
    chk("soft_ign", {1'b1, WRS_ST_INIT}, {rst_n, st_o});
    i_wrs_host_model.wd_write(3'h1, 1'b0, 1'b0);
    i_wrs_host_model.mode_write(WRS_MODE_SOFTRST);
    wait_rst(1'b0, 5);
    chk("soft_init", {5'h0, WRS_ST_INIT}, {5'h0, st_o});
    wait_rst(1'b1, DLY + 10);
    // Config 2: the count stops at one and every failure restarts
    cfg_i = 2'h1;
    i_wrs_host_model.wd_write(3'h1, 1'b0, 1'b0);
    wait_rst(1'b0, 130);
    wait_rst(1'b1, DLY + 10);
    wait_rst(1'b0, 230);
    chk("cfg2_sat", {WRS_ST_RESTART, 2'h1}, {st_o, cnt_o});
    fse_i = 1'b1;
    tick(1);
    fse_i = 1'b0;
    chk("fs_clear", {WRS_ST_FAILSAFE, 2'h0}, {st_o, cnt_o});
    // Fail-safe entered from the event input is left only through power-on reset
    nrst_i = 1'b0;
    tick(2);
    chk("rst_again", {WRS_ST_INIT, 1'b0}, {st_o, rst_n});
    nrst_i = 1'b1;
    cfg_i = 2'h0;
    wait_rst(1'b1, DLY + 10);
    i_wrs_host_model.wd_write(3'h1, 1'b0, 1'b0);
    dev_i = 1'b1;
    tick(300);
    chk("dev_mode", 8'h8, {4'h0, rst_n, cnt_o, run_o});
    uv_i = 1'b1;
    tick(3);
    chk("uv_filter", 8'h1, {7'h0, rst_n});
    tick(5);
    chk("uv_low", 8'h0, {7'h0, rst_n});
    tick(10);
    uv_i = 1'b0;
    wait_rst(1'b1, DLY + 10);
    chk("uv_delay", 8'h1, {7'h0, n >= DLY - 1});
    i_wrs_host_model.mode_write(WRS_MODE_SLEEP);
    tick(2);
    chk("sleep", {WRS_ST_SLEEP, 2'h0, 1'b0}, {st_o, cnt_o, run_o});
    wrap_up();
  end
endmodule
bind wrs_supervisor wrs_supervisor_chk #(.FILTER_CYC(FILTER_CYC), .DELAY_CYC(DELAY_CYC))
  i_wrs_supervisor_chk (.clk_i(clk_i), .nrst_i(nrst_i), .vcc_good_i(vcc_good_i),
  .uv_event_i(uv_event_i), .dev_mode_i(dev_mode_i), .config_sel_i(config_sel_i),
  .cs_rise_i(cs_rise_i), .mode_wr_i(mode_wr_i), .mode_field_i(mode_field_i),
  .wcr_wr_i(wcr_wr_i), .wcr_data_i(wcr_data_i), .reset_out_n_o(reset_out_n_o),
  .state_o(state_o), .window_type_select_o(window_type_select_o),
  .period_select_field_o(period_select_field_o),
  .trigger_failure_count_o(trigger_failure_count_o), .spi_fail_o(spi_fail_o),
  .wd_running_o(wd_running_o));

/* bench/wrs_host_model.sv */
// Host controller model: frames mode, watchdog and configuration writes
`timescale 1ns/1ps
module wrs_host_model
  import wrs_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Decoded frame towards the supervisor
  output logic cs_rise_o,
  output logic mode_wr_o,
  output logic [1:0] mode_field_o,
  output logic wcr_wr_o,
  output logic [WCR_WIDTH-1:0] wcr_data_o,
  output logic cfg_wr_o,
  output logic srro_o,
  output logic [1:0] thr_o
);
  initial begin
    {cs_rise_o, mode_wr_o, wcr_wr_o, cfg_wr_o} = 4'h0;
    {mode_field_o, wcr_data_o, srro_o, thr_o} = 13'h0;
  end
  // Fields are already set; chip select rises for one cycle
  task automatic frame(input logic m, input logic w, input logic c);
    @(posedge clk_i);
    #1;
    {mode_wr_o, wcr_wr_o, cfg_wr_o} = {m, w, c};
    cs_rise_o = 1'b1;
    @(posedge clk_i);
    #1;
    {cs_rise_o, mode_wr_o, wcr_wr_o, cfg_wr_o} = 4'h0;
    // Released lines must not keep showing the last word
    {mode_field_o, wcr_data_o, srro_o, thr_o} = ~{mode_field_o, wcr_data_o, srro_o, thr_o};
    @(posedge clk_i);
    #1;
  endtask
  task automatic wd_write(input logic [2:0] per, input logic win, input logic bad);
    logic [7:0] w;
    w = {3'h0, win, 1'b0, per};
    w[7] = (^w[6:0]) ^ bad;
    wcr_data_o = w;
    frame(1'b0, 1'b1, 1'b0);
  endtask
  task automatic mode_write(input logic [1:0] m);
    mode_field_o = m;
    frame(1'b1, 1'b0, 1'b0);
  endtask
  task automatic cfg_write(input logic s, input logic [1:0] t);
    srro_o = s;
    thr_o = t;
    frame(1'b0, 1'b0, 1'b1);
  endtask
endmodule

/* bench/wrs_supervisor_chk_sva.sv */
// Port-level property checker of the reset and watchdog supervisor
`timescale 1ns/1ps
module wrs_supervisor_chk
  import wrs_pkg::*;
#(
  parameter int unsigned FILTER_CYC = RESET_FILTER_CYC,
  parameter int unsigned DELAY_CYC = RESET_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Watched inputs
  input wire logic vcc_good_i,
  input wire logic uv_event_i,
  input wire logic dev_mode_i,
  input wire logic [1:0] config_sel_i,
  input wire logic cs_rise_i,
  input wire logic mode_wr_i,
  input wire logic [1:0] mode_field_i,
  input wire logic wcr_wr_i,
  input wire logic [WCR_WIDTH-1:0] wcr_data_i,
  // Watched outputs
  input wire logic reset_out_n_o,
  input wire logic [2:0] state_o,
  input wire logic window_type_select_o,
  input wire logic [2:0] period_select_field_o,
  input wire logic [1:0] trigger_failure_count_o,
  input wire logic spi_fail_o,
  input wire logic wd_running_o
);
  logic [31:0] ev_q, ev_d, low_q, low_d;
  logic soft_req;
  assign soft_req = cs_rise_i && mode_wr_i && mode_field_i == WRS_MODE_SOFTRST;
  // Run length of the event, and of a low output with a healthy supply
  always_comb begin
    ev_d = uv_event_i ? ev_q + 32'h1 : 32'h0;
    low_d = (reset_out_n_o || uv_event_i || !vcc_good_i) ? 32'h0 : low_q + 32'h1;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_q <= 32'h0;
      low_q <= 32'h0;
    end else begin
      ev_q <= ev_d;
      low_q <= low_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_event_pulls_low: assert property (ev_q > FILTER_CYC + 1 |-> !reset_out_n_o)
    else $error("reset output high during a lasting event");
  a_release_delay: assert property ($rose(reset_out_n_o) |-> low_q >= DELAY_CYC - 1)
    else $error("reset output released before the delay");
  a_trigger_failure_count_low: assert property (trigger_failure_count_o > $past(trigger_failure_count_o)
    |-> ##[0:3] !reset_out_n_o)
    else $error("failure count rose without a reset");
  a_count_sat: assert property (trigger_failure_count_o <= ((config_sel_i == CFG_TWO) ?
    FAIL_SAT_CFG2 : FAIL_SAT_OTHER))
    else $error("failure count beyond its saturation");
  a_trig_clears: assert property (cs_rise_i && wcr_wr_i && !(^wcr_data_i) && !dev_mode_i &&
    state_o == WRS_ST_NORMAL && !window_type_select_o |=> trigger_failure_count_o == 2'h0)
    else $error("good trigger left the failure count set");
  a_parity_drop: assert property (cs_rise_i && wcr_wr_i && ^wcr_data_i
    |=> spi_fail_o && $stable(period_select_field_o) && $stable(window_type_select_o))
    else $error("odd parity watchdog word not refused");
  a_soft_ignored: assert property (soft_req && !(state_o inside {WRS_ST_NORMAL, WRS_ST_STOP})
    |=> $stable(state_o))
    else $error("soft reset taken outside normal and stop");
  a_soft_to_init: assert property (soft_req && state_o == WRS_ST_NORMAL
    |-> ##[1:3] state_o == WRS_ST_INIT)
    else $error("soft reset did not return to init");
  a_dev_wd_off: assert property (dev_mode_i |-> !wd_running_o)
    else $error("watchdog running in development mode");
  a_sleep_wd_off: assert property (state_o == WRS_ST_SLEEP [*2]
    |-> !wd_running_o && trigger_failure_count_o == 2'h0)
    else $error("watchdog active in sleep");
  c_wd_reset: cover property (state_o == WRS_ST_RESTART);
  c_window_fail: cover property (window_type_select_o && trigger_failure_count_o != 2'h0);
  c_uv_reset: cover property (uv_event_i && $fell(reset_out_n_o));
endmodule

/* hdl/wrs_period_select_field.sv */
// Watchdog period counter with closed window and long open window
`timescale 1ns/1ps
module wrs_period_select_field
  import wrs_pkg::*;
#(
  parameter int unsigned MS_CYC = CYC_PER_MS,
  parameter int unsigned LONG_CYC = LONG_WINDOW_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic long_i,
  input wire logic [2:0] period_i,
  // State
  output logic closed_o,
  output logic expired_o
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic long_q, long_d;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] closed_lim;

  always_comb begin
    limit = long_q ? CNT_W'(LONG_CYC) : CNT_W'(wrs_period_ms(period_i) * MS_CYC);
    closed_lim = CNT_W'((wrs_period_ms(period_i) * MS_CYC / PCT_FULL) * CLOSED_PCT);
    cnt_d = cnt_q;
    long_d = long_q;
    expired_o = 1'b0;
    if (!run_i) begin
      cnt_d = '0;
      long_d = 1'b1;
    end else if (restart_i) begin
      cnt_d = '0;
      long_d = long_i;
    end else if (cnt_q >= limit - 1'b1) begin
      expired_o = 1'b1;
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      long_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      long_q <= long_d;
    end
  end

  // The long open window never has a closed part
  assign closed_o = !long_q && (cnt_q < closed_lim);
endmodule

/* hdl/wrs_pkg.sv */
// Constants, modes and timing counts of the reset and watchdog supervisor
package wrs_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  // Timing figures in their own units
  localparam int unsigned RESET_FILTER_US = 10;
  localparam int unsigned RESET_DELAY_US = 10_000;
  localparam int unsigned LONG_WINDOW_MS = 200;
  localparam int unsigned CLOSED_PCT = 60;
  localparam int unsigned PCT_FULL = 100;
  // Least times converted to whole cycles; the divisions truncate
  localparam int unsigned RESET_FILTER_CYC = (RESET_FILTER_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RESET_DELAY_CYC = (RESET_DELAY_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned LONG_WINDOW_CYC = LONG_WINDOW_MS * CYC_PER_MS;
  // Mode field encodings
  typedef enum logic [1:0] {
    WRS_MODE_NORMAL = 2'h0,
    WRS_MODE_SLEEP = 2'h1,
    WRS_MODE_STOP = 2'h2,
    WRS_MODE_SOFTRST = 2'h3
  } wrs_mode_cmd_t;
  // Device operating modes
  typedef enum logic [2:0] {
    WRS_ST_INIT,
    WRS_ST_NORMAL,
    WRS_ST_STOP,
    WRS_ST_SLEEP,
    WRS_ST_RESTART,
    WRS_ST_FAILSAFE
  } wrs_state_t;
  // Watchdog control word layout
  localparam int unsigned WCR_WIDTH = 8;
  localparam int unsigned WCR_PERIOD_LSB = 0;
  localparam int unsigned WCR_PERIOD_W = 3;
  localparam int unsigned WCR_WIN_BIT = 4;
  localparam logic [2:0] PERIOD_DEFAULT = 3'h1;
  localparam logic [1:0] FAIL_SAT_CFG2 = 2'h1;
  localparam logic [1:0] FAIL_SAT_OTHER = 2'h2;
  localparam logic [1:0] CFG_TWO = 2'h1;
  localparam logic [1:0] THR_DEFAULT = 2'h0;
  localparam int unsigned CNT_W = 28;
  // Period table in ms for settings 1..7
  function automatic int unsigned wrs_period_ms(input logic [2:0] sel);
    case (sel)
      3'h1: wrs_period_ms = 10;
      3'h2: wrs_period_ms = 20;
      3'h3: wrs_period_ms = 50;
      3'h4: wrs_period_ms = 100;
      3'h5: wrs_period_ms = 200;
      3'h6: wrs_period_ms = 500;
      3'h7: wrs_period_ms = 1000;
      default: wrs_period_ms = 10;
    endcase
  endfunction
endpackage

/* hdl/wrs_reset_gen.sv */
// Reset output timer: filter on assertion, delay on release
`timescale 1ns/1ps
module wrs_reset_gen
  import wrs_pkg::*;
#(
  parameter int unsigned FILTER_CYC = RESET_FILTER_CYC,
  parameter int unsigned DELAY_CYC = RESET_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Event in, reset out
  input wire logic event_i,
  input wire logic pulse_i,
  output logic reset_out_n_o,
  output logic release_o
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic low_q, low_d;

  always_comb begin
    low_d = low_q;
    cnt_d = cnt_q;
    release_o = 1'b0;
    if (!low_q) begin
      if (pulse_i) begin
        low_d = 1'b1;
        cnt_d = '0;
      end else if (event_i) begin
        // Short glitches below the filter time do not pull the output
        if (cnt_q >= CNT_W'(FILTER_CYC - 1)) begin
          low_d = 1'b1;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end else begin
        cnt_d = '0;
      end
    end else if (event_i || pulse_i) begin
      cnt_d = '0;
    end else if (cnt_q >= CNT_W'(DELAY_CYC - 1)) begin
      low_d = 1'b0;
      cnt_d = '0;
      release_o = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_q <= 1'b1;
      cnt_q <= '0;
    end else begin
      low_q <= low_d;
      cnt_q <= cnt_d;
    end
  end

  assign reset_out_n_o = !low_q;
endmodule

/* hdl/wrs_supervisor.sv */
// Reset output, soft reset and watchdog supervision of the chip
// Behaviour
// - Reset event pulls reset low after filter, holds, releases after delay.
// - At power-up reset stays low until regulator good, then delay.
// - Watchdog failure is a reset event.
// - Undervoltage threshold selectable; default lowest after initialisation.
// - Mode field 11 requests soft reset: back to init, defaults restored.
// - Soft reset ignored outside normal and stop modes.
// - Config bit chooses whether soft reset pulses the reset output.
// - Type bit selects time-out (default) or window watchdog.
// - Watchdog settings writable only in init and normal; stop keeps them unless off.
// - Watchdog off in sleep/restart; init starts long window after release.
// - New timing restarts the watchdog timer at once.
// - Valid watchdog register write triggers at chip select rising edge.
// - After init, restart or some stop cases, 200 ms long window.
// - Period settings 1..7 give 10,20,50,100,200,500,1000 ms.
// - Period applies to both watchdog types.
// - Watchdog reset enters restart or fail-safe and updates failure count.
// - On reset release after watchdog reset: long window, normal mode.
// - Development mode disables watchdog completely.
// - Failure count increments on closed-window trigger or expiry.
// - Count saturates at 01 in config 2, 10 otherwise.
// - Count clears after successful trigger.
// - Count clears when watchdog off: stop disable, sleep, other fail-safe.
// - Time-out trigger anytime restarts period; expiry resets.
// - Window type: first 60% closed; trigger there resets.
// - Watchdog write needs even parity over 8 bits, else ignored, flag set.
`timescale 1ns/1ps
module wrs_supervisor
  import wrs_pkg::*;
#(
  parameter int unsigned FILTER_CYC = RESET_FILTER_CYC,
  parameter int unsigned DELAY_CYC = RESET_DELAY_CYC,
  parameter int unsigned MS_CYC = CYC_PER_MS,
  parameter int unsigned LONG_CYC = LONG_WINDOW_CYC
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Supply and fault inputs
  input wire logic vcc_good_i,
  input wire logic uv_event_i,
  input wire logic fail_safe_event_i,
  input wire logic dev_mode_i,
  input wire logic [1:0] config_sel_i,
  // Command port, one decoded SPI frame per chip select rise
  input wire logic cs_rise_i,
  input wire logic mode_wr_i,
  input wire logic [1:0] mode_field_i,
  input wire logic wcr_wr_i,
  input wire logic [WCR_WIDTH-1:0] wcr_data_i,
  input wire logic cfg_wr_i,
  input wire logic softrst_pulses_reset_out_i,
  input wire logic [1:0] uv_threshold_i,
  input wire logic wd_stop_off_i,
  input wire logic spi_fail_clr_i,
  // Outputs
  output logic reset_out_n_o,
  output logic [2:0] state_o,
  output logic window_type_select_o,
  output logic [2:0] period_select_field_o,
  output logic [1:0] trigger_failure_count_o,
  output logic [1:0] uv_threshold_o,
  output logic softrst_pulses_reset_out_o,
  output logic spi_fail_o,
  output logic wd_running_o
);
  wrs_state_t st_q, st_d;
  logic win_q, win_d;
  logic [2:0] per_q, per_d;
  logic [1:0] fail_q, fail_d;
  logic [1:0] thr_q, thr_d;
  logic srro_q, srro_d;
  logic stopoff_q, stopoff_d;
  logic spif_q, spif_d;
  logic wdrst_q, wdrst_d;
  logic sr_pulse_q, sr_pulse_d;

  logic rst_release;
  logic wd_closed;
  logic wd_expired;
  logic wd_restart;
  logic wd_long;
  logic wd_run;
  logic trigger_failure_count;
  logic trig;
  logic parity_ok;
  logic softrst;
  logic [1:0] fail_sat;

  assign parity_ok = ~^wcr_data_i;
  assign trig = cs_rise_i && wcr_wr_i && parity_ok;
  // Watchdog runs only where it is on and the reset output is released
  assign wd_run = !dev_mode_i && reset_out_n_o &&
                  ((st_q == WRS_ST_INIT) || (st_q == WRS_ST_NORMAL) ||
                   ((st_q == WRS_ST_STOP) && !stopoff_q));
  assign trigger_failure_count = wd_run && (wd_expired || (trig && win_q && wd_closed));
  assign softrst = cs_rise_i && mode_wr_i && (mode_field_i == WRS_MODE_SOFTRST) &&
                   ((st_q == WRS_ST_NORMAL) || (st_q == WRS_ST_STOP));
  assign fail_sat = (config_sel_i == CFG_TWO) ? FAIL_SAT_CFG2 : FAIL_SAT_OTHER;

  always_comb begin
    st_d = st_q;
    win_d = win_q;
    per_d = per_q;
    fail_d = fail_q;
    thr_d = thr_q;
    srro_d = srro_q;
    stopoff_d = stopoff_q;
    spif_d = spif_q && !spi_fail_clr_i;
    wdrst_d = wdrst_q;
    sr_pulse_d = 1'b0;
    wd_restart = 1'b0;
    wd_long = 1'b0;
    if (cs_rise_i && wcr_wr_i && !parity_ok) begin
      spif_d = 1'b1;
    end
    if (cs_rise_i && cfg_wr_i && (st_q == WRS_ST_NORMAL || st_q == WRS_ST_INIT)) begin
      thr_d = uv_threshold_i;
      srro_d = softrst_pulses_reset_out_i;
      stopoff_d = wd_stop_off_i;
    end
    if (trigger_failure_count) begin
      // Failure wins over a trigger in the same cycle
      fail_d = (fail_q >= fail_sat) ? fail_sat : fail_q + 2'h1;
      wdrst_d = 1'b1;
      st_d = (fail_q >= fail_sat - 2'h1 && config_sel_i != CFG_TWO) ?
             WRS_ST_FAILSAFE : WRS_ST_RESTART;
    end else if (trig && wd_run) begin
      fail_d = 2'h0;
      wd_restart = 1'b1;
      if (st_q == WRS_ST_NORMAL || st_q == WRS_ST_INIT) begin
        win_d = wcr_data_i[WCR_WIN_BIT];
        per_d = (wcr_data_i[WCR_PERIOD_LSB +: WCR_PERIOD_W] == 3'h0) ? per_q :
                wcr_data_i[WCR_PERIOD_LSB +: WCR_PERIOD_W];
      end
      if (st_q == WRS_ST_INIT) begin
        st_d = WRS_ST_NORMAL;
      end
    end
    if (cs_rise_i && mode_wr_i && !softrst && !trigger_failure_count) begin
      if (st_q == WRS_ST_NORMAL && mode_field_i == WRS_MODE_STOP) begin
        st_d = WRS_ST_STOP;
      end else if (st_q == WRS_ST_NORMAL && mode_field_i == WRS_MODE_SLEEP) begin
        st_d = WRS_ST_SLEEP;
      end else if (st_q == WRS_ST_STOP && mode_field_i == WRS_MODE_NORMAL) begin
        st_d = WRS_ST_NORMAL;
        stopoff_d = 1'b0;
        wd_restart = 1'b1;
        wd_long = 1'b1;
      end
    end
    if (st_q == WRS_ST_SLEEP || (st_q == WRS_ST_STOP && stopoff_q) || dev_mode_i) begin
      fail_d = 2'h0;
    end
    if (fail_safe_event_i) begin
      st_d = WRS_ST_FAILSAFE;
      fail_d = 2'h0;
      wdrst_d = 1'b0;
    end
    if (rst_release && (st_q == WRS_ST_RESTART || wdrst_q)) begin
      st_d = WRS_ST_NORMAL;
      wdrst_d = 1'b0;
      wd_restart = 1'b1;
      wd_long = 1'b1;
    end
    if (softrst) begin
      // Every setting back to default, failure count included
      st_d = WRS_ST_INIT;
      win_d = 1'b0;
      per_d = PERIOD_DEFAULT;
      fail_d = 2'h0;
      thr_d = THR_DEFAULT;
      srro_d = 1'b1;
      stopoff_d = 1'b0;
      spif_d = 1'b0;
      wdrst_d = 1'b0;
      sr_pulse_d = srro_q;
      wd_restart = 1'b1;
      wd_long = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= WRS_ST_INIT;
      win_q <= 1'b0;
      per_q <= PERIOD_DEFAULT;
      fail_q <= 2'h0;
      thr_q <= THR_DEFAULT;
      srro_q <= 1'b1;
      stopoff_q <= 1'b0;
      spif_q <= 1'b0;
      wdrst_q <= 1'b0;
      sr_pulse_q <= 1'b0;
    end else begin
      st_q <= st_d;
      win_q <= win_d;
      per_q <= per_d;
      fail_q <= fail_d;
      thr_q <= thr_d;
      srro_q <= srro_d;
      stopoff_q <= stopoff_d;
      spif_q <= spif_d;
      wdrst_q <= wdrst_d;
      sr_pulse_q <= sr_pulse_d;
    end
  end

  // Reset held low from power-on until regulator good, then delayed release
  wrs_reset_gen #(
    .FILTER_CYC(FILTER_CYC),
    .DELAY_CYC(DELAY_CYC)
  ) u_rst (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    // A watchdog failure goes through the pulse path; held as a level it would
    // keep the delay counter cleared and the output low for good
    .event_i(!vcc_good_i || uv_event_i),
    .pulse_i(sr_pulse_q || trigger_failure_count),
    .reset_out_n_o(reset_out_n_o),
    .release_o(rst_release)
  );

  wrs_period_select_field #(
    .MS_CYC(MS_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_wd (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(wd_run),
    .restart_i(wd_restart),
    .long_i(wd_long),
    .period_i(per_q),
    .closed_o(wd_closed),
    .expired_o(wd_expired)
  );

  assign state_o = st_q;
  assign window_type_select_o = win_q;
  assign period_select_field_o = per_q;
  assign trigger_failure_count_o = fail_q;
  assign uv_threshold_o = thr_q;
  assign softrst_pulses_reset_out_o = srro_q;
  assign spi_fail_o = spif_q;
  assign wd_running_o = wd_run;
endmodule
